// File: eism_host_model.sv
`timescale 1ns/1ns
module eism_host_model
    import eism_pkg::*;
(
    input wire logic clk,
    input wire logic ser_wire,
    input wire logic go,
    input wire logic quiet,
    output logic host_low,
    output logic [NUM_IRQ-1:0] seen,
    output logic [7:0] nfr
);
logic [SLOT_COUNT-1:0] cap;
logic by_go;
// one frame, opened by go or by a device pull while idle;
// one process owns every output so nothing has two drivers
initial begin
    host_low = 1'b0;
    seen = '0;
    nfr = 8'h00;
    forever begin
        @(posedge clk);
        if (go || !ser_wire) begin
            by_go = go;
            #1 host_low = 1'b1;
            // a device pull already gave the first low clock
            repeat (by_go ? 4 : 3) @(posedge clk);
            #1 host_low = 1'b0;
            // recovery and turnaround edges; the next edge is slot 0
            repeat (2) @(posedge clk);
            cap = '1;
            for (int n = 0; n < SLOT_COUNT; n++) begin
                repeat (3) begin
                    @(posedge clk);
                    cap[n] = cap[n] & ser_wire;
                end
            end
            #1 host_low = 1'b1;
            repeat (quiet ? 2 : 3) @(posedge clk);
            #1 host_low = 1'b0;
            seen = cap[NUM_IRQ-1:0];
            nfr = nfr + 8'h01;
        end
    end
end
endmodule

// File: eism_merge.sv
`timescale 1ns/1ns
module eism_merge
    import eism_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic SER_IRQ_IN,
    output logic SER_IRQ_OUT,
    output logic SER_IRQ_OE,
    input wire logic [NUM_EXT-1:0] EXT_IRQ,
    input wire logic [NUM_EXT-1:0] PIN_IRQ_FUNC,
    input wire logic [NUM_UNIT*SEL_W-1:0] UNIT_IRQ_SEL,
    input wire logic [NUM_UNIT-1:0] UNIT_EN,
    input wire logic [NUM_UNIT-1:0] UNIT_IRQ,
    input wire logic [SEL_W-1:0] KBD_IRQ_SEL,
    input wire logic KBD_IRQ,
    input wire logic [SEL_W-1:0] MOUSE_IRQ_SEL,
    input wire logic MOUSE_IRQ,
    input wire logic [7:0] WATCHDOG_CONFIG_REGISTER,
    input wire logic WATCHDOG_IRQ,
    output logic [NUM_IRQ-1:0] SLOT_LEVEL,
    output logic [NUM_EXT-1:0] EXT_BLOCKED,
    output logic QUIET_MODE
);

    // ------------------------------------------------------------
    // source gathering
    // ------------------------------------------------------------
    logic [NUM_DEV*SEL_W-1:0] dev_sel;
    logic [NUM_DEV-1:0] dev_en;
    logic [NUM_DEV-1:0] dev_irq;
    logic [SEL_W-1:0] wdog_sel;
    logic [NUM_IRQ-1:0] merged;
    logic [NUM_IRQ-1:0] blk;
    logic [NUM_EXT-1:0] ext_blk;

    assign wdog_sel = WATCHDOG_CONFIG_REGISTER[WDOG_SEL_POS +: SEL_W];
    assign dev_sel = {wdog_sel, MOUSE_IRQ_SEL, KBD_IRQ_SEL, UNIT_IRQ_SEL};
    // units without an enable bit are enabled by a nonzero select
    assign dev_en = {wdog_sel != SEL_NONE,
                     MOUSE_IRQ_SEL != SEL_NONE,
                     KBD_IRQ_SEL != SEL_NONE,
                     UNIT_EN};
    assign dev_irq = {WATCHDOG_IRQ, MOUSE_IRQ, KBD_IRQ, UNIT_IRQ};

    // ------------------------------------------------------------
    // one merge cell per irq number
    // ------------------------------------------------------------
    generate
        for (genvar n = 0; n < NUM_IRQ; n++) begin : g_slot
            eism_slot #(
                .IRQ_NUM(n),
                .EXT_IDX(ext_index(n))
            ) u_slot (
                .dev_sel(dev_sel),
                .dev_en(dev_en),
                .dev_irq(dev_irq),
                .ext_irq(EXT_IRQ),
                .ext_func(PIN_IRQ_FUNC),
                .req(merged[n]),
                .blocked(blk[n])
            );
        end
        // fold blocking flags back onto pin order
        for (genvar p = 0; p < NUM_EXT; p++) begin : g_blk
            assign ext_blk[p] = blk[EXT_IRQ_MAP[p*SEL_W +: SEL_W]];
        end
    endgenerate

    // ------------------------------------------------------------
    // registered status
    // ------------------------------------------------------------
    // slot levels are also the snapshot used for quiet-mode starts
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            SLOT_LEVEL <= 16'h0000;
            EXT_BLOCKED <= 8'h00;
        end else begin
            SLOT_LEVEL <= merged;
            EXT_BLOCKED <= ext_blk;
        end
    end

    // ------------------------------------------------------------
    // serial frame tracking
    // ------------------------------------------------------------
    eism_state_t state_r, state_nxt;
    logic [4:0] slot_r, slot_nxt;
    logic [1:0] phase_r, phase_nxt;
    logic [3:0] low_r, low_nxt;
    logic [NUM_IRQ-1:0] sent_r;
    logic start_req;
    logic drove_start_r;
    logic oe_nxt;
    logic out_nxt;

    // a level change since the last frame asks for a quiet-mode start
    assign start_req = QUIET_MODE && (SLOT_LEVEL != sent_r) &&
                       !drove_start_r;

    always_comb begin
        state_nxt = state_r;
        slot_nxt = slot_r;
        phase_nxt = phase_r;
        low_nxt = low_r;
        case (state_r)
            ST_IDLE: begin
                if (!SER_IRQ_IN) begin
                    state_nxt = ST_START;
                    low_nxt = 4'h1;
                end
            end
            ST_START: begin
                if (SER_IRQ_IN) begin
                    // this high clock is the recovery of the start
                    state_nxt = ST_LEAD;
                end else if (low_r != LOW_CNT_MAX) begin
                    low_nxt = low_r + 4'h1;
                end
            end
            ST_LEAD: begin
                // turnaround, then slot 0 sample phase
                state_nxt = ST_SLOTS;
                slot_nxt = 5'h00;
                phase_nxt = PH_SAMPLE;
            end
            ST_SLOTS: begin
                if (phase_r == PH_TURN) begin
                    phase_nxt = PH_SAMPLE;
                    if (slot_r == LAST_SLOT) begin
                        state_nxt = ST_STOP;
                        low_nxt = 4'h0;
                    end else begin
                        slot_nxt = slot_r + 5'h01;
                    end
                end else begin
                    phase_nxt = phase_r + 2'h1;
                end
            end
            ST_STOP: begin
                if (!SER_IRQ_IN) begin
                    if (low_r != LOW_CNT_MAX) begin
                        low_nxt = low_r + 4'h1;
                    end
                end else if (low_r != 4'h0) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // drive decisions follow the next phase so the pin flops line up
    always_comb begin
        oe_nxt = 1'b0;
        out_nxt = 1'b1;
        if (state_r == ST_IDLE && SER_IRQ_IN && start_req) begin
            oe_nxt = 1'b1;
            out_nxt = 1'b0;
        end else if (state_nxt == ST_SLOTS && slot_nxt < 5'(NUM_IRQ)) begin
            // deasserted irq pulls low, asserted irq floats high
            if (!SLOT_LEVEL[slot_nxt[3:0]]) begin
                if (phase_nxt == PH_SAMPLE) begin
                    oe_nxt = 1'b1;
                    out_nxt = 1'b0;
                end else if (phase_nxt == PH_RECOVER) begin
                    oe_nxt = 1'b1;
                    out_nxt = 1'b1;
                end
            end
        end
    end

    // frame position
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            state_r <= ST_IDLE;
            slot_r <= 5'h00;
            phase_r <= PH_SAMPLE;
            low_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            slot_r <= slot_nxt;
            phase_r <= phase_nxt;
            low_r <= low_nxt;
        end
    end

    // pin drivers straight from flops
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            SER_IRQ_OE <= 1'b0;
            SER_IRQ_OUT <= 1'b1;
            drove_start_r <= 1'b0;
        end else begin
            SER_IRQ_OE <= oe_nxt;
            SER_IRQ_OUT <= out_nxt;
            drove_start_r <= (state_r == ST_IDLE) && oe_nxt;
        end
    end

    // remember what each sample phase reported
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            sent_r <= 16'h0000;
        end else if (state_nxt == ST_SLOTS && phase_nxt == PH_SAMPLE &&
                     slot_nxt < 5'(NUM_IRQ)) begin
            sent_r[slot_nxt[3:0]] <= SLOT_LEVEL[slot_nxt[3:0]];
        end
    end

    // stop frame length selects the mode of the next frame
    always_ff @(posedge MCLK or negedge NRST) begin
        if (!NRST) begin
            QUIET_MODE <= 1'b0;
        end else if (state_r == ST_STOP && SER_IRQ_IN && low_r != 4'h0) begin
            QUIET_MODE <= (low_r == STOP_QUIET_LEN);
        end
    end

endmodule

// File: eism_merge_bench.sv
`timescale 1ns/1ns
module eism_merge_bench
    import eism_pkg::*;
;
logic clk = 1'b0, nrst = 1'b0, go = 1'b0, quiet = 1'b0;
logic host_low, ser_wire, oe, out, qm;
logic [NUM_EXT-1:0] ext = '0, func = '0, blkd;
logic [NUM_UNIT*SEL_W-1:0] usel = '0;
logic [NUM_UNIT-1:0] uen = '0, ureq = '0;
logic [SEL_W-1:0] ksel = '0, msel = '0;
logic kreq = 1'b0, mreq = 1'b0, wreq = 1'b0;
logic [7:0] wcfg = 8'h00, nfr;
logic [NUM_IRQ-1:0] slot, seen, m;
int num_errors = 0;
int compares = 0;
int irq_tab [8] = '{3, 4, 5, 7, 9, 10, 11, 15};

always #50 clk = ~clk;
// released wire floats high through the pull-up
assign ser_wire = oe ? out : !host_low;

eism_merge dut (.MCLK(clk), .NRST(nrst), .SER_IRQ_IN(ser_wire),
    .SER_IRQ_OUT(out), .SER_IRQ_OE(oe), .EXT_IRQ(ext),
    .PIN_IRQ_FUNC(func), .UNIT_IRQ_SEL(usel), .UNIT_EN(uen),
    .UNIT_IRQ(ureq), .KBD_IRQ_SEL(ksel), .KBD_IRQ(kreq),
    .MOUSE_IRQ_SEL(msel), .MOUSE_IRQ(mreq),
    .WATCHDOG_CONFIG_REGISTER(wcfg), .WATCHDOG_IRQ(wreq),
    .SLOT_LEVEL(slot), .EXT_BLOCKED(blkd), .QUIET_MODE(qm));
eism_host_model host (.clk(clk), .ser_wire(ser_wire), .go(go),
    .quiet(quiet), .host_low(host_low), .seen(seen), .nfr(nfr));

task automatic tick(int n);
    repeat (n) @(posedge clk);
    #1;
endtask

task automatic chk(string nm, logic [31:0] exp, logic [31:0] got);
    compares++;
    if (got !== exp) begin
        num_errors++;
        $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
endtask

task automatic report_and_stop;
    $display("compares %0d errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
        $display("All tests passed");
    end else begin
        $display("Some tests failed");
    end
    $finish;
endtask

// wait for the host to finish a frame, bounded
task automatic frame(logic q, logic g);
    logic [7:0] n0;
    n0 = nfr;
    quiet = q;
    go = g;
    tick(1);
    go = 1'b0;
    for (int i = 0; i < 300 && nfr == n0; i++) tick(1);
    if (nfr == n0) begin
        chk("frame timeout", 1, 0);
        report_and_stop;
    end
    tick(2);
endtask

initial begin
    tick(16);
    nrst = 1'b1;
    ext = 8'hFF;
    tick(2);
    chk("slot no func", 0, slot);
    // no unit owns these irqs, so each pin reaches its own slot
    for (int i = 0; i < NUM_EXT; i++) begin
        func = 8'h01 << i;
        tick(2);
        chk("slot pin", 32'h1 << irq_tab[i], slot);
    end
    $display("test pin routing done");
    func = 8'hFF;
    m = 16'h8EB8;
    for (int d = 0; d < NUM_UNIT; d++) begin
        usel[d*SEL_W +: SEL_W] = SEL_W'(irq_tab[d]);
        tick(2);
        chk("slot sel off", m, slot);
        uen[d] = 1'b1;
        tick(2);
        chk("slot unit en", m & ~(16'h1 << irq_tab[d]), slot);
        chk("blocked", (32'h2 << d) - 1, blkd);
        ureq[d] = 1'b1;
        tick(2);
        chk("slot unit req", m, slot);
    end
    $display("test unit enables done");
    ksel = 4'hA;
    msel = 4'hB;
    wcfg = 8'hF0;
    tick(2);
    chk("slot kbd", 16'h02B8, slot);
    chk("blocked all", 8'hFF, blkd);
    {kreq, mreq, wreq} = 3'h7;
    tick(2);
    chk("slot kbd req", m, slot);
    $display("test select enables done");
    // irq1 has no pin; pin of irq10 is free again
    ksel = 4'h1;
    ureq = 5'h15;
    tick(2);
    frame(1'b0, 1'b1);
    chk("frame slots", 16'h8E2A, seen);
    chk("quiet off", 0, qm);
    frame(1'b1, 1'b1);
    chk("quiet on", 1, qm);
    // a level change in quiet mode lets the device open the frame
    ureq = 5'h1F;
    frame(1'b0, 1'b0);
    chk("quiet start slots", 16'h8EBA, seen);
    chk("quiet off again", 0, qm);
    $display("test frames done");
    report_and_stop;
end
endmodule

// File: eism_merge_properties.sv
`timescale 1ns/1ns
module eism_merge_properties
    import eism_pkg::*;
(
    input wire logic MCLK,
    input wire logic NRST,
    input wire logic SER_IRQ_OUT,
    input wire logic SER_IRQ_OE,
    input wire logic [NUM_EXT-1:0] EXT_IRQ,
    input wire logic [NUM_EXT-1:0] PIN_IRQ_FUNC,
    input wire logic [NUM_UNIT*SEL_W-1:0] UNIT_IRQ_SEL,
    input wire logic [NUM_UNIT-1:0] UNIT_EN,
    input wire logic [NUM_UNIT-1:0] UNIT_IRQ,
    input wire logic [SEL_W-1:0] KBD_IRQ_SEL,
    input wire logic KBD_IRQ,
    input wire logic [SEL_W-1:0] MOUSE_IRQ_SEL,
    input wire logic MOUSE_IRQ,
    input wire logic [7:0] WATCHDOG_CONFIG_REGISTER,
    input wire logic WATCHDOG_IRQ,
    input wire logic [NUM_IRQ-1:0] SLOT_LEVEL,
    input wire logic [NUM_EXT-1:0] EXT_BLOCKED
);
logic [SEL_W-1:0] sel [NUM_DEV];
logic [SEL_W-1:0] q;
logic [NUM_DEV-1:0] rq, en;
logic [NUM_IRQ-1:0] own, oreq, pin;
logic [NUM_EXT-1:0] blk;

// reference merge; owners without an enable count by select alone
always_comb begin
    for (int d = 0; d < NUM_UNIT; d++) begin
        sel[d] = UNIT_IRQ_SEL[d*SEL_W +: SEL_W];
    end
    sel[DEV_KBD] = KBD_IRQ_SEL;
    sel[DEV_MOUSE] = MOUSE_IRQ_SEL;
    sel[DEV_WDOG] = WATCHDOG_CONFIG_REGISTER[WDOG_SEL_POS +: SEL_W];
    rq = {WATCHDOG_IRQ, MOUSE_IRQ, KBD_IRQ, UNIT_IRQ};
    en = {3'h7, UNIT_EN};
    own = '0;
    oreq = '0;
    pin = '0;
    for (int d = 0; d < NUM_DEV; d++) begin
        if (en[d] && sel[d] != SEL_NONE) begin
            own[sel[d]] = 1'b1;
            oreq[sel[d]] = oreq[sel[d]] | rq[d];
        end
    end
    for (int i = 0; i < NUM_EXT; i++) begin
        q = EXT_IRQ_MAP[i*SEL_W +: SEL_W];
        pin[q] = EXT_IRQ[i] & PIN_IRQ_FUNC[i];
        blk[i] = PIN_IRQ_FUNC[i] & own[q];
    end
end

default clocking cb @(posedge MCLK); endclocking
default disable iff (!NRST);
sequence s_low; SER_IRQ_OE && !SER_IRQ_OUT; endsequence
sequence s_high; SER_IRQ_OE && SER_IRQ_OUT; endsequence

a_owned_slot: assert property ($past(NRST) |->
    (SLOT_LEVEL & $past(own)) == $past(oreq)) else $error("owned slot");
a_free_pin: assert property ($past(NRST) |->
    (SLOT_LEVEL & ~$past(own)) == ($past(pin) & ~$past(own)))
    else $error("free pin slot");
a_block_flag: assert property ($past(NRST) |->
    EXT_BLOCKED == $past(blk)) else $error("blocked flags");
a_kbd_slot: assert property ($past(NRST && KBD_IRQ &&
    KBD_IRQ_SEL != SEL_NONE) |-> SLOT_LEVEL[$past(KBD_IRQ_SEL)])
    else $error("keyboard slot");
a_wdog_slot: assert property ($past(NRST && WATCHDOG_IRQ &&
    sel[DEV_WDOG] != SEL_NONE) |-> SLOT_LEVEL[$past(sel[DEV_WDOG])])
    else $error("watchdog slot");
a_reset_clear: assert property ($rose(NRST) |->
    SLOT_LEVEL == '0 && EXT_BLOCKED == '0) else $error("reset levels");
a_low_once: assert property (s_low |=> !s_low)
    else $error("double low");
a_turn_after: assert property (s_high |=> !SER_IRQ_OE)
    else $error("no turnaround");
endmodule

bind eism_merge eism_merge_properties chk (.MCLK, .NRST, .SER_IRQ_OUT,
    .SER_IRQ_OE, .EXT_IRQ, .PIN_IRQ_FUNC, .UNIT_IRQ_SEL, .UNIT_EN,
    .UNIT_IRQ, .KBD_IRQ_SEL, .KBD_IRQ, .MOUSE_IRQ_SEL, .MOUSE_IRQ,
    .WATCHDOG_CONFIG_REGISTER, .WATCHDOG_IRQ, .SLOT_LEVEL, .EXT_BLOCKED);

// File: eism_pkg.sv
package eism_pkg;

    // ------------------------------------------------------------
    // source layout
    // ------------------------------------------------------------
    localparam int NUM_IRQ = 16;
    localparam int SEL_W = 4;
    localparam int NUM_UNIT = 5;
    localparam int NUM_DEV = 8;
    localparam int NUM_EXT = 8;
    // internal source order: floppy, uart1, uart2, uart3, parallel,
    // keyboard, mouse, watchdog
    localparam int DEV_KBD = 5;
    localparam int DEV_MOUSE = 6;
    localparam int DEV_WDOG = 7;
    localparam logic [SEL_W-1:0] SEL_NONE = 4'h0;
    // irq number field inside the watchdog configuration byte
    localparam int WDOG_SEL_POS = 4;

    // irq numbers of the eight muxed pins, pin 0 in the low nibble
    localparam logic [NUM_EXT*SEL_W-1:0] EXT_IRQ_MAP = 32'hFBA97543;

    // ------------------------------------------------------------
    // serial frame timing, in clocks
    // ------------------------------------------------------------
    localparam int SLOT_COUNT = 21;
    localparam logic [4:0] LAST_SLOT = 5'h14;
    localparam logic [1:0] PH_SAMPLE = 2'h0;
    localparam logic [1:0] PH_RECOVER = 2'h1;
    localparam logic [1:0] PH_TURN = 2'h2;
    localparam logic [3:0] STOP_QUIET_LEN = 4'h2;
    localparam logic [3:0] LOW_CNT_MAX = 4'hF;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_LEAD,
        ST_SLOTS,
        ST_STOP
    } eism_state_t;

    // pin index that carries a given irq number, or -1
    function automatic int ext_index(input int irq);
        int idx;
        idx = -1;
        for (int i = 0; i < NUM_EXT; i++) begin
            if (int'(EXT_IRQ_MAP[i*SEL_W +: SEL_W]) == irq) begin
                idx = i;
            end
        end
        return idx;
    endfunction

endpackage

// File: eism_slot.sv
`timescale 1ns/1ns
module eism_slot
    import eism_pkg::*;
#(
    parameter int IRQ_NUM = 0,
    parameter int EXT_IDX = -1
) (
    input wire logic [NUM_DEV*SEL_W-1:0] dev_sel,
    input wire logic [NUM_DEV-1:0] dev_en,
    input wire logic [NUM_DEV-1:0] dev_irq,
    input wire logic [NUM_EXT-1:0] ext_irq,
    input wire logic [NUM_EXT-1:0] ext_func,
    output logic req,
    output logic blocked
);

    logic owned;
    logic int_req;
    logic ext_req;

    // ------------------------------------------------------------
    // internal claim of this irq number
    // ------------------------------------------------------------
    // an owner needs both the matching select and its enable
    always_comb begin
        owned = 1'b0;
        int_req = 1'b0;
        for (int d = 0; d < NUM_DEV; d++) begin
            if (dev_sel[d*SEL_W +: SEL_W] == IRQ_NUM[SEL_W-1:0] &&
                dev_sel[d*SEL_W +: SEL_W] != SEL_NONE && dev_en[d]) begin
                owned = 1'b1;
                int_req = int_req | dev_irq[d];
            end
        end
    end

    // ------------------------------------------------------------
    // external pin path
    // ------------------------------------------------------------
    generate
        if (EXT_IDX >= 0) begin : g_ext
            // only a pin set to its irq function is looked at
            assign ext_req = ext_func[EXT_IDX] & ext_irq[EXT_IDX];
            assign blocked = owned & ext_func[EXT_IDX];
        end else begin : g_noext
            assign ext_req = 1'b0;
            assign blocked = 1'b0;
        end
    endgenerate

    // internal owner wins, otherwise the pin fills the slot
    assign req = owned ? int_req : ext_req;

endmodule
